// >>> core/dpsem_defs.vh
`ifndef DPSEM_DEFS_VH
`define DPSEM_DEFS_VH

// Pin bus widths, semaphore index width and flag count
`define DPSEM_ADDR_W        15
`define DPSEM_DATA_W        16
`define DPSEM_IDX_W         3
`define DPSEM_NUM_FLAGS     8

// Host command codes
`define DPSEM_CMD_W         2
`define DPSEM_CMD_CLAIM     2'h0
`define DPSEM_CMD_RELEASE   2'h1
`define DPSEM_CMD_READ      2'h2
`define DPSEM_CMD_MEMWRITE  2'h3

// Field positions
`define DPSEM_FLAG_BIT      0

// Timing, ns as printed for the pin cycle budget
`define DPSEM_CLK_NS        4
`define DPSEM_SETUP_NS      20
`define DPSEM_STROBE_NS     20
`define DPSEM_BUSY_NS       20
`define DPSEM_SETUP_CYC     ((`DPSEM_SETUP_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_STROBE_CYC    ((`DPSEM_STROBE_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_BUSY_CYC      ((`DPSEM_BUSY_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_CNT_W         4

// Pin reset values
`define DPSEM_DATA_RST      16'hffff

`endif

// >>> core/dpsem_sync.v
`timescale 1ns/1ns
// =====================================================================
// Three-stage input synchroniser, change accepted when stages 2 and 3 agree
module dpsem_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_srst,
  // Async in, filtered out
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  genvar g;

  always @(posedge i_clk) begin
    if (i_srst) begin
      s1_ff <= {W{1'b1}};
      s2_ff <= {W{1'b1}};
      s3_ff <= {W{1'b1}};
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge i_clk) begin
        if (i_srst) begin
          o_sync[g] <= 1'b1;
        end else if (s2_ff[g] == s3_ff[g]) begin
          o_sync[g] <= s3_ff[g];
        end
      end
    end
  endgenerate

endmodule

// >>> core/dpsem_host.v
`timescale 1ns/1ns
`include "dpsem_defs.vh"
// Contract
// - Array holds exactly one master part; avoids split busy decisions.
// - Hold address and enable until busy settles, then start write strobe.
// - Flags active low: write zero to request, one to release.
// - Claim by write then read back; use resource only when held.
// - After a failed claim, poll or withdraw and retry later.
module dpsem_host (
  // Clock and reset
  input  wire                        i_clk,
  input  wire                        i_srst,
  // Command port
  input  wire                        i_cmd_valid,
  input  wire [`DPSEM_CMD_W-1:0]     i_cmd_op,
  input  wire [`DPSEM_IDX_W-1:0]     i_cmd_index,
  input  wire [`DPSEM_ADDR_W-1:0]    i_cmd_addr,
  input  wire [`DPSEM_DATA_W-1:0]    i_cmd_wdata,
  output reg                         o_cmd_ready,
  output reg                         o_done,
  output reg                         o_granted,
  output reg                         o_busy_seen,
  output reg  [`DPSEM_DATA_W-1:0]    o_rdata,
  // Device port pins
  output reg  [`DPSEM_ADDR_W-1:0]    o_addr,
  output reg                         o_ce_n,
  output reg                         o_sem_n,
  output reg                         o_oe_n,
  output reg                         o_rw_n,
  output reg  [`DPSEM_DATA_W-1:0]    o_data,
  output reg                         o_data_oe,
  input  wire [`DPSEM_DATA_W-1:0]    i_data,
  input  wire                        i_busy_n
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_SETUP = 6'h02;
  localparam [5:0] ST_WSTRB = 6'h04;
  localparam [5:0] ST_GAP   = 6'h08;
  localparam [5:0] ST_RSTRB = 6'h10;
  localparam [5:0] ST_DONE  = 6'h20;

  // =====================================================================
  // Phase lengths, cut to the counter width on purpose
  localparam [31:0] SETUP_LD  = `DPSEM_SETUP_CYC;
  localparam [31:0] STROBE_LD = `DPSEM_STROBE_CYC;
  localparam [31:0] READ_LD   = `DPSEM_STROBE_CYC + `DPSEM_BUSY_CYC;

  reg [5:0]                  state_ff;
  reg [`DPSEM_CNT_W-1:0]     cnt_ff;
  reg [`DPSEM_CMD_W-1:0]     op_ff;
  wire [`DPSEM_DATA_W-1:0]   data_s;
  wire                       busy_n_s;

  // =====================================================================
  // Pin input synchronisation
  // One busy input only: a second master would split the busy decision
  dpsem_sync #(
    .W (`DPSEM_DATA_W + 1)
  ) u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_busy_n, i_data}),
    .o_sync  ({busy_n_s, data_s})
  );

  function is_sem;
    input [`DPSEM_CMD_W-1:0] op;
    begin
      is_sem = (op != `DPSEM_CMD_MEMWRITE);
    end
  endfunction

  function has_write;
    input [`DPSEM_CMD_W-1:0] op;
    begin
      has_write = (op != `DPSEM_CMD_READ);
    end
  endfunction

  // =====================================================================
  // Sequencer
  always @(posedge i_clk) begin
    if (i_srst) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= {`DPSEM_CNT_W{1'b0}};
      op_ff       <= `DPSEM_CMD_READ;
      o_cmd_ready <= 1'b0;
      o_done      <= 1'b0;
      o_granted   <= 1'b0;
      o_busy_seen <= 1'b0;
      o_rdata     <= {`DPSEM_DATA_W{1'b0}};
      o_addr      <= {`DPSEM_ADDR_W{1'b0}};
      o_ce_n      <= 1'b1;
      o_sem_n     <= 1'b1;
      o_oe_n      <= 1'b1;
      o_rw_n      <= 1'b1;
      o_data      <= `DPSEM_DATA_RST;
      o_data_oe   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // Both selects high keeps the port in standby
          o_ce_n      <= 1'b1;
          o_sem_n     <= 1'b1;
          o_oe_n      <= 1'b1;
          o_rw_n      <= 1'b1;
          o_data_oe   <= 1'b0;
          o_cmd_ready <= 1'b1;
          if (i_cmd_valid && o_cmd_ready) begin
            o_cmd_ready <= 1'b0;
            op_ff       <= i_cmd_op;
            o_busy_seen <= 1'b0;
            cnt_ff      <= SETUP_LD[`DPSEM_CNT_W-1:0];
            if (is_sem(i_cmd_op)) begin
              // Upper lines are don't-care in semaphore space
              o_addr  <= {{(`DPSEM_ADDR_W-`DPSEM_IDX_W){1'b0}}, i_cmd_index};
              o_sem_n <= 1'b0;
            end else begin
              o_addr <= i_cmd_addr;
              o_ce_n <= 1'b0;
            end
            // Request is zero, release is one, on the lowest line only
            if (i_cmd_op == `DPSEM_CMD_CLAIM) begin
              o_data <= {`DPSEM_DATA_W{1'b1}} << 1;
            end else if (i_cmd_op == `DPSEM_CMD_RELEASE) begin
              o_data <= {`DPSEM_DATA_W{1'b1}};
            end else begin
              o_data <= i_cmd_wdata;
            end
            state_ff <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Address and enable settle before strobe so busy can resolve
          if (cnt_ff != {`DPSEM_CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else if (has_write(op_ff)) begin
            o_busy_seen <= ~busy_n_s;
            o_rw_n      <= 1'b0;
            o_data_oe   <= 1'b1;
            cnt_ff      <= STROBE_LD[`DPSEM_CNT_W-1:0];
            state_ff    <= ST_WSTRB;
          end else begin
            o_oe_n   <= 1'b0;
            cnt_ff   <= STROBE_LD[`DPSEM_CNT_W-1:0];
            state_ff <= ST_RSTRB;
          end
        end
        ST_WSTRB: begin
          if (cnt_ff != {`DPSEM_CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            o_rw_n    <= 1'b1;
            o_data_oe <= 1'b0;
            // Claim must be verified by read-back, not assumed
            if (op_ff == `DPSEM_CMD_CLAIM) begin
              o_sem_n  <= 1'b1;
              cnt_ff   <= SETUP_LD[`DPSEM_CNT_W-1:0];
              state_ff <= ST_GAP;
            end else begin
              state_ff <= ST_DONE;
            end
          end
        end
        ST_GAP: begin
          // Select toggles so the device relatches a fresh flag value
          if (cnt_ff != {`DPSEM_CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            o_sem_n  <= 1'b0;
            o_oe_n   <= 1'b0;
            cnt_ff   <= READ_LD[`DPSEM_CNT_W-1:0];
            state_ff <= ST_RSTRB;
          end
        end
        ST_RSTRB: begin
          if (cnt_ff != {`DPSEM_CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            o_rdata <= data_s;
            // Flag replicated on all lines; low bit decides ownership
            o_granted <= ~data_s[`DPSEM_FLAG_BIT];
            o_oe_n    <= 1'b1;
            o_sem_n   <= 1'b1;
            state_ff  <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Failed claim: caller polls with READ or withdraws with RELEASE
          o_ce_n   <= 1'b1;
          o_done   <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> bench/dpsem_dev_model.sv
`timescale 1ns/1ns
// ==========
// One port of the device plus a far side steered by the bench
module dpsem_dev_model (
  // Pins from host
  input  wire [14:0] i_addr,
  input  wire        i_ce_n,
  input  wire        i_sem_n,
  input  wire        i_oe_n,
  input  wire        i_rw_n,
  input  wire [15:0] i_data,
  // Far side
  input  wire [7:0]  i_far_req_n,
  input  wire [14:0] i_far_addr,
  input  wire        i_far_ce,
  // Pins to host
  output wire [15:0] o_data,
  output wire        o_busy_n
);
  logic [7:0]  req_n = 8'hff;
  logic [7:0]  own   = 8'h00;
  logic [7:0]  far   = 8'h00;
  logic [15:0] q     = 16'hffff;
  logic        wr_q  = 1'b0;
  wire         sem_wr = !i_sem_n && !i_rw_n;
  // Flags steer nothing else; ports never wait on each other
  // Write ends on whichever of strobe or select rises first, no race
  always @(sem_wr) begin
    if (wr_q && !sem_wr) req_n[i_addr[2:0]] <= i_data[0];
    wr_q = sem_wr;
  end
  // Twice so a release hands over to a pending request
  always @(req_n or i_far_req_n)
    repeat (2) for (int k = 0; k < 8; k++) begin
      if (req_n[k]) own[k] = 1'b0;
      else if (!far[k]) own[k] = 1'b1;
      if (i_far_req_n[k]) far[k] = 1'b0;
      else if (!own[k]) far[k] = 1'b1;
    end
  always @(negedge i_oe_n or negedge i_sem_n)
    if (!i_oe_n && !i_sem_n) q <= {16{~own[i_addr[2:0]]}};
  // Released bus shows the inverse, never a stale value
  assign o_data = (!i_oe_n && !i_sem_n) ? q : ~q;
  assign o_busy_n = !(!i_ce_n && i_far_ce && i_addr == i_far_addr);
endmodule

// >>> bench/dpsem_host_sva.sv
`timescale 1ns/1ns
`include "dpsem_defs.vh"
module dpsem_host_sva (
  input wire                     i_clk,
  input wire                     i_srst,
  input wire                     o_cmd_ready,
  input wire                     o_granted,
  input wire [`DPSEM_DATA_W-1:0] o_rdata,
  input wire [`DPSEM_ADDR_W-1:0] o_addr,
  input wire                     o_ce_n,
  input wire                     o_sem_n,
  input wire                     o_oe_n,
  input wire                     o_rw_n,
  input wire [`DPSEM_DATA_W-1:0] o_data,
  input wire                     o_data_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_hold_strobe: assert property (!o_rw_n |-> $stable(o_addr) && $stable(o_sem_n))
    else $error("address moved during strobe");
  a_setup_time: assert property ($fell(o_rw_n) |-> $past(o_addr, 5) == o_addr
    && $past(o_ce_n, 5) == o_ce_n && $past(o_sem_n, 5) == o_sem_n)
    else $error("strobe without setup");
  a_write_drive: assert property (!o_rw_n |-> o_oe_n && o_data_oe)
    else $error("bad pins in write");
  a_sem_bit0: assert property (!o_sem_n && !o_rw_n |-> o_data[15:1] == 15'h7fff)
    else $error("semaphore write data");
  a_write_readback: assert property ($rose(o_rw_n) && !$past(o_sem_n)
    && !$past(o_data[0]) |-> ##[1:10] (!o_sem_n && !o_oe_n))
    else $error("claim not read back");
  a_idle_standby: assert property (o_cmd_ready |-> o_ce_n && o_sem_n && o_rw_n)
    else $error("idle not in standby");
  a_grant_flag: assert property ($rose(o_oe_n) && !$past(o_sem_n)
    |-> o_rdata == {`DPSEM_DATA_W{~o_granted}})
    else $error("grant does not follow flag");
  a_read_steady: assert property (!o_sem_n && !o_oe_n |=> o_oe_n || $stable(o_addr))
    else $error("address moved in read");
endmodule
bind dpsem_host dpsem_host_sva u_dpsem_host_sva (.i_clk(i_clk), .i_srst(i_srst),
  .o_cmd_ready(o_cmd_ready), .o_granted(o_granted), .o_rdata(o_rdata), .o_addr(o_addr),
  .o_ce_n(o_ce_n), .o_sem_n(o_sem_n), .o_oe_n(o_oe_n), .o_rw_n(o_rw_n),
  .o_data(o_data), .o_data_oe(o_data_oe));

// >>> bench/dpsem_host_tb.sv
`timescale 1ns/1ns
`include "dpsem_defs.vh"
module dpsem_host_tb;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_cmd_valid = 1'b0;
  logic [1:0]  i_cmd_op = 2'h0;
  logic [2:0]  i_cmd_index = 3'h0;
  logic [14:0] i_cmd_addr = 15'h0000;
  logic [15:0] i_cmd_wdata = 16'h0000;
  logic [7:0]  far_req_n = 8'hff;
  logic [14:0] far_addr = 15'h0000;
  logic        far_ce = 1'b0;
  wire         o_cmd_ready, o_done, o_granted, o_busy_seen;
  wire         o_ce_n, o_sem_n, o_oe_n, o_rw_n, o_data_oe, i_busy_n;
  wire [15:0]  o_rdata, o_data, i_data;
  wire [14:0]  o_addr;
  int          fail_count = 0;
  int          checked = 0;
  always #2 i_clk = ~i_clk;
  dpsem_host u_dpsem_host (.i_clk(i_clk), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_cmd_index(i_cmd_index), .i_cmd_addr(i_cmd_addr),
    .i_cmd_wdata(i_cmd_wdata), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
    .o_granted(o_granted), .o_busy_seen(o_busy_seen), .o_rdata(o_rdata), .o_addr(o_addr),
    .o_ce_n(o_ce_n), .o_sem_n(o_sem_n), .o_oe_n(o_oe_n), .o_rw_n(o_rw_n), .o_data(o_data),
    .o_data_oe(o_data_oe), .i_data(i_data), .i_busy_n(i_busy_n));
  dpsem_dev_model u_dpsem_dev_model (.i_addr(o_addr), .i_ce_n(o_ce_n),
    .i_sem_n(o_sem_n), .i_oe_n(o_oe_n), .i_rw_n(o_rw_n), .i_data(o_data),
    .i_far_req_n(far_req_n), .i_far_addr(far_addr), .i_far_ce(far_ce),
    .o_data(i_data), .o_busy_n(i_busy_n));
  task automatic conclude;
    if (fail_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic run(input logic [1:0] op, input logic [2:0] idx, input logic [14:0] adr);
    int n;
    n = 0;
    @(negedge i_clk);
    i_cmd_op = op;
    i_cmd_index = idx;
    i_cmd_addr = adr;
    i_cmd_wdata = 16'h5a5a;
    i_cmd_valid = 1'b1;
    while (o_cmd_ready !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    while (o_done !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 100) begin
      fail_count++;
      conclude();
    end
  endtask
  // ==========
  // Scenarios
  task automatic t_claim_free;
    run(`DPSEM_CMD_CLAIM, 3'h5, 15'h7ff8);
    chk("granted", 16'h0001, {15'h0000, o_granted});
    chk("rdata", 16'h0000, o_rdata);
    run(`DPSEM_CMD_RELEASE, 3'h5, 15'h0000);
    run(`DPSEM_CMD_READ, 3'h5, 15'h0000);
    chk("rdata", 16'hffff, o_rdata);
  endtask
  task automatic t_claim_held;
    far_req_n = 8'hf7;
    run(`DPSEM_CMD_CLAIM, 3'h3, 15'h0000);
    chk("granted", 16'h0000, {15'h0000, o_granted});
    chk("rdata", 16'hffff, o_rdata);
    far_req_n = 8'hff;
    run(`DPSEM_CMD_READ, 3'h3, 15'h0000);
    chk("granted", 16'h0001, {15'h0000, o_granted});
    run(`DPSEM_CMD_RELEASE, 3'h3, 15'h0000);
  endtask
  task automatic t_busy;
    far_ce = 1'b1;
    far_addr = 15'h1234;
    run(`DPSEM_CMD_MEMWRITE, 3'h0, 15'h1234);
    chk("busy_seen", 16'h0001, {15'h0000, o_busy_seen});
    run(`DPSEM_CMD_MEMWRITE, 3'h0, 15'h1235);
    chk("busy_seen", 16'h0000, {15'h0000, o_busy_seen});
    far_ce = 1'b0;
  endtask
  initial begin
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    t_claim_free();
    t_claim_held();
    t_busy();
    conclude();
  end
endmodule
